// >>> rsdc_top.sv
`timescale 1ns/10ps
// Reset strap capture and default configuration
module rsdc_top
	import rsdc_pkg::*;
#(
	parameter int N_MOD = NUM_MODULES
)(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              test_nrst,
	input  wire logic              max_rst_req,
	input  wire logic [ADDR_W-1:0] async_mem_address_pin,
	input  wire logic              boot_start,
	input  wire logic              sw_cfg_we,
	input  wire logic [1:0]        sw_boot_sel,
	input  wire logic [3:0]        sw_pin_cfg,
	output logic      [1:0]        boot_source_select,
	output logic      [3:0]        async_mem_pin_config,
	output logic                   strap_mode,
	output logic                   warm_rst_flag,
	output logic                   emu_rst_n,
	output logic                   pll_bypass,
	output logic                   pll_enable,
	output logic                   defaults_active,
	output rsdc_pinmux_t           pinmux_ff,
	output rsdc_bootif_t           bootif_ff,
	output logic                   boot_status_pin_oe,
	output logic                   boot_status_pin,
	output logic      [N_MOD-1:0]  mod_enable_ff,
	output logic      [N_MOD-1:0]  mod_power_on_ff
);

	// Every numbered module must fit in the enable vector
	if (N_MOD <= MOD_FIX_HI) begin : g_bad_n_mod
		$error("N_MOD too small");
	end

	// ------------------------------------------------------------
	// Reset qualification
	// ------------------------------------------------------------
	logic        in_rst_ff;
	logic [1:0]  cap_boot_ff;
	logic [3:0]  cap_cfg_ff;
	rsdc_state_t state_ff;
	rsdc_state_t nxt_state;
	logic [3:0]  pin_cfg_ff;
	logic [1:0]  boot_sel_ff;
	rsdc_pinmux_t  nxt_pinmux;
	logic [N_MOD-1:0] nxt_mod_en;

	// Capture phase: any reset source, max reset same as warm
	wire capture = in_rst_ff | max_rst_req; // R20

	// Reset tracker: high for first cycle after release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_rst_ff <= 1'b1;
		end else begin
			in_rst_ff <= max_rst_req;
		end
	end

	// Warm vs power-on: test reset high marks warm
	always_ff @(posedge sys_clk or negedge test_nrst) begin
		if (!test_nrst) begin
			emu_rst_n <= 1'b0;
		end else begin
			emu_rst_n <= 1'b1; // R21
		end
	end

	// Warm flag caught after release, clocked
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			warm_rst_flag <= 1'b0;
		end else if (in_rst_ff) begin
			warm_rst_flag <= emu_rst_n | max_rst_req; // R21 R20
		end
	end

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Follows pins while capture is high (max reset, first edge after nrst release), frozen afterwards
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cap_boot_ff <= BOOT_SEL_RST; // R4
			cap_cfg_ff  <= PIN_CFG_RST; // R4
		end else if (capture) begin
			cap_boot_ff <= async_mem_address_pin[BOOT_SEL_MSB:BOOT_SEL_LSB]; // R1 R23
			cap_cfg_ff  <= async_mem_address_pin[PIN_CFG_MSB:PIN_CFG_LSB]; // R1 R23
		end
	end

	// Strap mode output: pins are strap inputs only while capturing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			strap_mode <= 1'b1;
		end else begin
			strap_mode <= max_rst_req; // R2
		end
	end

	// ------------------------------------------------------------
	// Configuration held until software rewrites
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_sel_ff <= BOOT_SEL_RST;
			pin_cfg_ff  <= PIN_CFG_RST;
		end else if (capture) begin
			boot_sel_ff <= async_mem_address_pin[BOOT_SEL_MSB:BOOT_SEL_LSB]; // R23
			pin_cfg_ff  <= async_mem_address_pin[PIN_CFG_MSB:PIN_CFG_LSB]; // R23
		end else if (sw_cfg_we && state_ff == RSDC_ST_BOOT) begin
			boot_sel_ff <= sw_boot_sel; // R1 R12
			pin_cfg_ff  <= sw_pin_cfg; // R1 R12
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_source_select   <= BOOT_SEL_RST;
			async_mem_pin_config <= PIN_CFG_RST;
		end else begin
			boot_source_select   <= boot_sel_ff;
			async_mem_pin_config <= pin_cfg_ff;
		end
	end

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= RSDC_ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RSDC_ST_RESET:   nxt_state = capture ? RSDC_ST_RESET : RSDC_ST_DEFAULT;
			RSDC_ST_DEFAULT: begin
				if (capture)
					nxt_state = RSDC_ST_RESET;
				else if (boot_start)
					nxt_state = RSDC_ST_BOOT; // R12
			end
			RSDC_ST_BOOT:    nxt_state = capture ? RSDC_ST_RESET : RSDC_ST_BOOT;
			default:         nxt_state = RSDC_ST_RESET;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			defaults_active <= 1'b0;
		end else begin
			defaults_active <= (nxt_state == RSDC_ST_DEFAULT); // R12
		end
	end

	// PLLs bypassed and disabled from any reset, held with no software path to change them
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pll_bypass <= 1'b1; // R11
			pll_enable <= 1'b0; // R11
		end else if (capture) begin
			pll_bypass <= 1'b1; // R11
			pll_enable <= 1'b0; // R11
		end
	end

	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	rsdc_pin_decode u_pin (
		.pin_cfg (pin_cfg_ff),
		.pinmux  (nxt_pinmux)
	);

	rsdc_module_decode #(
		.N_MOD (N_MOD)
	) u_mod (
		.boot_sel   (boot_sel_ff),
		.mod_enable (nxt_mod_en)
	);

	// Pin partition applies for NAND and direct memory boots
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinmux_ff <= '0;
		end else if (boot_sel_ff == RSDC_BOOT_NAND || boot_sel_ff == RSDC_BOOT_AMEM) begin
			pinmux_ff <= nxt_pinmux; // R5 R6 R22
		end else begin
			pinmux_ff <= '0;
		end
	end

	// Boot interface selection
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bootif_ff <= '0;
		end else begin
			bootif_ff.rom_boot   <= (boot_sel_ff != RSDC_BOOT_AMEM); // R3
			bootif_ff.use_cs0    <= (boot_sel_ff == RSDC_BOOT_NAND) |
			                        (boot_sel_ff == RSDC_BOOT_AMEM); // R8 R9
			bootif_ff.use_sport0 <= (boot_sel_ff == RSDC_BOOT_NAND); // R8
			bootif_ff.use_card0  <= (boot_sel_ff == RSDC_BOOT_CARD); // R10
			bootif_ff.use_uart_zero  <= (boot_sel_ff == RSDC_BOOT_UART); // R3
		end
	end

	// Status pin driven low as output under ROM boot
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_status_pin_oe <= 1'b0;
			boot_status_pin    <= 1'b0;
		end else begin
			boot_status_pin_oe <= (boot_sel_ff != RSDC_BOOT_AMEM) && !capture; // R7
			boot_status_pin    <= 1'b0;
		end
	end

	// Module defaults: all powered, enables from boot select
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mod_enable_ff   <= '0;
			mod_power_on_ff <= '0;
		end else begin
			mod_enable_ff   <= capture ? '0 : nxt_mod_en; // R13
			mod_power_on_ff <= '1; // R13
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_release;
		capture ##1 !capture;
	endsequence

	chk_strap_freeze: assert property (@(posedge sys_clk) disable iff (!nrst) // R23
		!capture |=> $stable(cap_boot_ff) && $stable(cap_cfg_ff))
		else $error("strap changed after capture");
	// Cycles with nrst low hold reset values, so they are skipped
	chk_strap_follow: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		nrst && capture |=> cap_cfg_ff == $past(async_mem_address_pin[PIN_CFG_MSB:PIN_CFG_LSB]))
		else $error("strap not captured");
	chk_pins_revert: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
		s_release |=> !strap_mode)
		else $error("pins not returned");
	chk_pll_bypass: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
		capture |=> pll_bypass && !pll_enable)
		else $error("pll not bypassed");
	chk_card_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
		!capture |=> mod_enable_ff[MOD_CARD0] == ($past(boot_sel_ff) == 2'h2))
		else $error("card enable wrong");
	chk_uart_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
		!capture |=> mod_enable_ff[MOD_UART_ZERO] == ($past(boot_sel_ff) == 2'h3))
		else $error("uart enable wrong");
	chk_dma_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
		!capture |=> mod_enable_ff[MOD_DMA_TC0] == ($past(boot_sel_ff) != 2'h2))
		else $error("dma enable wrong");
	chk_sport_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R18
		!capture |=> mod_enable_ff[MOD_SPORT0] == ($past(boot_sel_ff) != 2'h1))
		else $error("serial port enable wrong");
	chk_status_pin: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		!capture && boot_sel_ff != 2'h1 |=> boot_status_pin_oe && !boot_status_pin)
		else $error("status pin not driven");
	chk_default_phase: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		s_release |-> ##1 defaults_active)
		else $error("defaults not active");

	// ------------------------------------------------------------
	// Module state and boot interface checks
	// ------------------------------------------------------------
	sequence s_max_hit;
		max_rst_req ##1 in_rst_ff;
	endsequence

	sequence s_boot_write;
		state_ff == RSDC_ST_BOOT && sw_cfg_we && !capture;
	endsequence

	// Boot dependent enables, timer zero, fixed set and power
	chk_cc_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
		!capture |=> mod_enable_ff[MOD_DMA_CC] == ($past(boot_sel_ff) != 2'h2))
		else $error("dma channel enable wrong");
	chk_amem_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
		!capture |=> mod_enable_ff[MOD_AMEM] == ($past(boot_sel_ff) != 2'h2))
		else $error("memory interface enable wrong");
	chk_timer_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
		!capture |=> mod_enable_ff[MOD_TIMER_ZERO])
		else $error("timer enable wrong");
	chk_fixed_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
		!capture |=> &mod_enable_ff[MOD_FIX_HI:MOD_FIX_LO])
		else $error("fixed set not enabled");
	chk_power_on: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
		!capture |=> &mod_power_on_ff)
		else $error("module domain not powered");

	// Boot interface choice follows the held select
	chk_rom_boot: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		!capture |=> bootif_ff.rom_boot == ($past(boot_sel_ff) != 2'h1))
		else $error("rom boot flag wrong");
	chk_cs0_select: assert property (@(posedge sys_clk) disable iff (!nrst) // R8 R9
		!capture |=> bootif_ff.use_cs0 == ($past(boot_sel_ff) <= 2'h1))
		else $error("chip select zero use wrong");
	chk_sport_boot: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
		!capture |=> bootif_ff.use_sport0 == ($past(boot_sel_ff) == 2'h0))
		else $error("serial port boot use wrong");
	chk_card_boot: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		!capture |=> bootif_ff.use_card0 == ($past(boot_sel_ff) == 2'h2))
		else $error("card boot use wrong");
	chk_uart_boot: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		!capture |=> bootif_ff.use_uart_zero == ($past(boot_sel_ff) == 2'h3))
		else $error("uart boot use wrong");

	// Pin partition and status pin
	chk_pinmux_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
		boot_sel_ff[1] |=> pinmux_ff == '0)
		else $error("pin partition outside memory boots");
	chk_burst_flash: assert property (@(posedge sys_clk) disable iff (!nrst) // R22
		!boot_sel_ff[1] && pin_cfg_ff == PIN_CFG_BURST |=> pinmux_ff.burst_flash && pinmux_ff.data16)
		else $error("burst flash not selected");
	chk_status_off: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		boot_sel_ff == 2'h1 |=> !boot_status_pin_oe)
		else $error("status pin driven in direct boot");

	// Software writes, phase and reset kind
	chk_sw_refused: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		state_ff != RSDC_ST_BOOT && !capture |=> $stable(boot_sel_ff) && $stable(pin_cfg_ff))
		else $error("write taken before boot");
	chk_sw_write: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		s_boot_write |=> boot_sel_ff == $past(sw_boot_sel) && pin_cfg_ff == $past(sw_pin_cfg))
		else $error("software write lost");
	chk_default_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		defaults_active && !boot_start && !capture |=> defaults_active)
		else $error("default phase left early");
	chk_warm_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
		s_max_hit |=> warm_rst_flag)
		else $error("max reset not marked warm");

endmodule : rsdc_top

// >>> rsdc_pkg.sv
// Functional notes
// R1: Straps captured on power-on, warm and max reset; held until software reprograms.
// R2: After capture, shared strap pins return to memory interface function automatically.
// R3: Boot select 00 NAND, 01 direct memory, 10 card, 11 UART.
// R4: Boot select from address pins 13:12 default 00; pin config 11:8 default 1101.
// R5: Pin config value sets address, data and GPIO partition after reset.
// R6: Pin config applies in direct memory boot and NAND boot.
// R7: Any ROM boot mode uses general-purpose pin 61 as boot status output.
// R8: NAND boot uses chip select zero and serial port zero.
// R9: Direct memory boot fetches from device on chip select zero.
// R10: Card boot uses card controller zero.
// R11: After reset all PLLs disabled and bypassed; chip runs from reference clock.
// R12: Defaults hold from reset end until boot; firmware may then change them.
// R13: All modules in powered permanent domain; others in sync reset except fixed set.
// R14: DMA channel and transfer controller zero enabled except for boot select 10.
// R15: Memory interface enabled except for boot select 10.
// R16: Card controller zero enabled only for boot select 10.
// R17: UART zero enabled only for boot select 11.
// R18: Serial port zero enabled except for boot select 01.
// R19: Timer zero enabled for all boot selects.
// R20: Max reset acts as warm reset, including strap re-capture.
// R21: Warm reset is reset pin low with test reset high; emulation kept.
// R22: Pin config 0010 selects burst flash with 16-bit data bus.
// R23: Capture follows pins during reset, freezes at release, then drives defaults. Code holds reset values while nrst is low.
package rsdc_pkg;

	// ------------------------------------------------------------
	// Strap field positions on the address pins
	// ------------------------------------------------------------
	localparam int BOOT_SEL_MSB = 13;
	localparam int BOOT_SEL_LSB = 12;
	localparam int PIN_CFG_MSB  = 11;
	localparam int PIN_CFG_LSB  = 8;
	localparam int ADDR_W       = 16;
	localparam int NUM_MODULES  = 41;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [1:0] BOOT_SEL_RST  = 2'h0;
	localparam logic [3:0] PIN_CFG_RST   = 4'hD;
	localparam logic [3:0] PIN_CFG_BURST = 4'h2;
	localparam logic [3:0] PIN_CFG_SRAM8 = 4'h8;
	localparam logic [3:0] PIN_CFG_NONE  = 4'h0;
	localparam logic [3:0] PIN_CFG_A14   = 4'hA;
	localparam logic [3:0] PIN_CFG_BA1   = 4'hC;

	// Module numbers with boot dependent state, plus timer zero which is enabled for every boot select
	localparam int MOD_DMA_CC   = 2;
	localparam int MOD_DMA_TC0  = 3;
	localparam int MOD_AMEM     = 14;
	localparam int MOD_CARD0    = 15;
	localparam int MOD_UART_ZERO    = 19;
	localparam int MOD_SPORT0   = 22;
	localparam int MOD_TIMER_ZERO   = 27;
	// Fixed always enabled modules 29..38
	localparam int MOD_FIX_LO   = 29;
	localparam int MOD_FIX_HI   = 38;

	// Timing: capture freeze is one cycle after release
	localparam int CAPTURE_CYCLES = 1;

	typedef enum logic [1:0] {
		RSDC_BOOT_NAND,
		RSDC_BOOT_AMEM,
		RSDC_BOOT_CARD,
		RSDC_BOOT_UART
	} rsdc_boot_t;

	typedef enum {
		RSDC_ST_RESET,
		RSDC_ST_DEFAULT,
		RSDC_ST_BOOT
	} rsdc_state_t;

	// Decoded pin partition
	typedef struct packed {
		logic [4:0] addr_width;   // Address bits enabled above A2:1
		logic       data16;       // Upper data byte enabled
		logic       burst_flash;
	} rsdc_pinmux_t;

	// Boot interface choice
	typedef struct packed {
		logic rom_boot;
		logic use_cs0;
		logic use_sport0;
		logic use_card0;
		logic use_uart_zero;
	} rsdc_bootif_t;

endpackage : rsdc_pkg

// >>> rsdc_pin_decode.sv
`timescale 1ns/10ps
// Pin config to memory pin partition
module rsdc_pin_decode
	import rsdc_pkg::*;
(
	input  wire logic [3:0] pin_cfg,
	output rsdc_pinmux_t    pinmux
);

	// ------------------------------------------------------------
	// Partition table
	// ------------------------------------------------------------
	always_comb begin
		pinmux = '0;
		case (pin_cfg) // R5
			PIN_CFG_RST:   pinmux = '{addr_width: 5'h0, data16: 1'b0, burst_flash: 1'b0};
			PIN_CFG_BA1:   pinmux = '{addr_width: 5'hE, data16: 1'b0, burst_flash: 1'b0};
			PIN_CFG_A14:   pinmux = '{addr_width: 5'hF, data16: 1'b0, burst_flash: 1'b0};
			PIN_CFG_SRAM8: pinmux = '{addr_width: 5'h10, data16: 1'b0, burst_flash: 1'b0};
			PIN_CFG_BURST: pinmux = '{addr_width: 5'hF, data16: 1'b1, burst_flash: 1'b1}; // R22
			PIN_CFG_NONE:  pinmux = '{addr_width: 5'h10, data16: 1'b1, burst_flash: 1'b0};
			default:       pinmux = '0;
		endcase
	end

endmodule : rsdc_pin_decode

// >>> rsdc_module_decode.sv
`timescale 1ns/10ps
// Boot select to per-module enable map
module rsdc_module_decode
	import rsdc_pkg::*;
#(
	parameter int N_MOD = NUM_MODULES
)(
	input  wire logic [1:0]       boot_sel,
	output logic      [N_MOD-1:0] mod_enable
);

	// Every numbered module must fit in the enable vector
	if (N_MOD <= MOD_FIX_HI) begin : g_bad_n_mod
		$error("N_MOD too small");
	end

	// ------------------------------------------------------------
	// One entry per module
	// ------------------------------------------------------------
	for (genvar i = 0; i < N_MOD; i++) begin : g_mod
		always_comb begin
			if (i == MOD_DMA_CC || i == MOD_DMA_TC0 || i == MOD_AMEM) begin
				mod_enable[i] = (boot_sel != 2'h2); // R14 R15
			end else if (i == MOD_CARD0) begin
				mod_enable[i] = (boot_sel == 2'h2); // R16
			end else if (i == MOD_UART_ZERO) begin
				mod_enable[i] = (boot_sel == 2'h3); // R17
			end else if (i == MOD_SPORT0) begin
				mod_enable[i] = (boot_sel != 2'h1); // R18
			end else if (i == MOD_TIMER_ZERO) begin
				mod_enable[i] = 1'b1; // R19
			end else begin
				mod_enable[i] = (i >= MOD_FIX_LO && i <= MOD_FIX_HI); // R13
			end
		end
	end

endmodule : rsdc_module_decode

// >>> rsdc_strap_board.sv
`timescale 1ns/10ps
// Board side of the shared strap pins: pulls during reset, memory traffic after
module rsdc_strap_board
	import rsdc_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              strap_mode,
	input  wire logic              max_rst_req,
	input  wire logic              fit_en,
	input  wire logic [1:0]        fit_boot_sel,
	input  wire logic [3:0]        fit_pin_cfg,
	output logic      [ADDR_W-1:0] pins
);
	logic [ADDR_W-1:0] bus_ff = 16'h5A3C;
	logic [ADDR_W-1:0] strap_val;

	// Memory traffic pattern, changes every cycle
	always_ff @(posedge sys_clk) begin
		bus_ff <= bus_ff + 16'h1357;
	end

	// Strap levels: fitted resistors or internal pull defaults
	always_comb begin
		strap_val = ~bus_ff;
		strap_val[BOOT_SEL_MSB:BOOT_SEL_LSB] = fit_en ? fit_boot_sel : BOOT_SEL_RST;
		strap_val[PIN_CFG_MSB:PIN_CFG_LSB] = fit_en ? fit_pin_cfg : PIN_CFG_RST;
	end

	// Straps only while sampled, interface traffic otherwise
	assign pins = (strap_mode | max_rst_req) ? strap_val : bus_ff;
endmodule : rsdc_strap_board

// >>> rsdc_top_tb.sv
`timescale 1ns/10ps
// Self-checking bench for strap capture and default configuration
module rsdc_top_tb;
	import rsdc_pkg::*;
	localparam int NM = NUM_MODULES;
	typedef struct packed {
		logic [1:0] bs;
		logic [3:0] cfg;
		logic       warm;
	} rsdc_note_t;

	logic sys_clk, nrst, test_nrst, max_rst_req, boot_start, sw_cfg_we;
	logic fit_en, defaults_active, strap_mode, warm_rst_flag;
	logic pll_bypass, pll_enable, status_oe, status_pin, da_q, emu_rst_n;
	logic [1:0]        fit_bs, sw_boot_sel, boot_source_select;
	logic [3:0]        fit_cfg, sw_pin_cfg, async_mem_pin_config;
	logic [ADDR_W-1:0] pins;
	logic [NM-1:0]     mod_enable_ff, mod_power_on_ff;
	rsdc_pinmux_t      pinmux_ff;
	rsdc_bootif_t      bootif_ff;
	rsdc_note_t        notes[$];
	rsdc_note_t        cur;
	int fails = 0;
	int n_checks = 0;
	int seed = 32'h115D38B7;
	logic [3:0] cfgs [6] = '{4'hD, 4'hC, 4'hA, 4'h8, 4'h2, 4'h0};

	// ------------------------------------------------------------
	// Clock, design and board
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	rsdc_top #(.N_MOD(NM)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .test_nrst(test_nrst),
		.max_rst_req(max_rst_req), .async_mem_address_pin(pins), .boot_start(boot_start),
		.sw_cfg_we(sw_cfg_we), .sw_boot_sel(sw_boot_sel), .sw_pin_cfg(sw_pin_cfg),
		.boot_source_select(boot_source_select), .async_mem_pin_config(async_mem_pin_config),
		.strap_mode(strap_mode), .warm_rst_flag(warm_rst_flag), .emu_rst_n(emu_rst_n),
		.pll_bypass(pll_bypass), .pll_enable(pll_enable), .defaults_active(defaults_active),
		.pinmux_ff(pinmux_ff), .bootif_ff(bootif_ff), .boot_status_pin_oe(status_oe),
		.boot_status_pin(status_pin), .mod_enable_ff(mod_enable_ff),
		.mod_power_on_ff(mod_power_on_ff));

	rsdc_strap_board u_board (.sys_clk(sys_clk), .strap_mode(strap_mode),
		.max_rst_req(max_rst_req), .fit_en(fit_en), .fit_boot_sel(fit_bs),
		.fit_pin_cfg(fit_cfg), .pins(pins));

	// ------------------------------------------------------------
	// Expected values and checking
	// ------------------------------------------------------------
	function automatic logic [NM-1:0] exp_mod(input logic [1:0] b);
		logic [NM-1:0] m;
		m = '0;
		m[MOD_DMA_CC] = (b != 2'h2);
		m[MOD_DMA_TC0] = (b != 2'h2);
		m[MOD_AMEM] = (b != 2'h2);
		m[MOD_CARD0] = (b == 2'h2);
		m[MOD_UART_ZERO] = (b == 2'h3);
		m[MOD_SPORT0] = (b != 2'h1);
		m[MOD_TIMER_ZERO] = 1'b1;
		for (int i = MOD_FIX_LO; i <= MOD_FIX_HI; i++) m[i] = 1'b1;
		return m;
	endfunction : exp_mod

	function automatic rsdc_bootif_t exp_bif(input logic [1:0] b);
		return '{b != 2'h1, b <= 2'h1, b == 2'h0, b == 2'h2, b == 2'h3};
	endfunction : exp_bif

	function automatic rsdc_pinmux_t exp_pmx(input logic [1:0] b, input logic [3:0] c);
		rsdc_pinmux_t p;
		p = '0;
		if (b <= 2'h1) begin
			case (c)
				4'hC: p.addr_width = 5'hE;
				4'hA, 4'h2: p.addr_width = 5'hF;
				4'h8, 4'h0: p.addr_width = 5'h10;
				default: p.addr_width = 5'h0;
			endcase
			p.data16 = (c == 4'h2) || (c == 4'h0);
			p.burst_flash = (c == 4'h2);
		end
		return p;
	endfunction : exp_pmx

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// Watcher: each entry to the default phase consumes the oldest note
	always @(negedge sys_clk) begin
		if (defaults_active === 1'b1 && da_q !== 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			check({boot_source_select, async_mem_pin_config}, {cur.bs, cur.cfg});
			check(strap_mode, 1'b0);
			check(pinmux_ff, exp_pmx(cur.bs, cur.cfg));
			check(bootif_ff, exp_bif(cur.bs));
			check({status_oe, status_pin & status_oe}, {cur.bs != 2'h1, 1'b0});
			check(mod_enable_ff, exp_mod(cur.bs));
			check(mod_power_on_ff, {NM{1'b1}});
			check({pll_bypass, pll_enable}, 2'h2);
			check(warm_rst_flag, cur.warm);
			check(emu_rst_n, 1'b1);
		end
		da_q = defaults_active;
	end

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	// Kind 0 power-on, 1 warm, 2 max; pulls leaves straps unfitted
	task automatic do_reset(input int kind, input logic [1:0] b, input logic [3:0] c,
		input bit pulls);
		rsdc_note_t n;
		int k;
		n.bs = pulls ? BOOT_SEL_RST : b;
		n.cfg = pulls ? PIN_CFG_RST : c;
		n.warm = (kind != 0);
		@(posedge sys_clk);
		fit_en <= !pulls;
		fit_bs <= b;
		fit_cfg <= c;
		if (kind == 2)
			max_rst_req <= 1'b1;
		else begin
			nrst <= 1'b0;
			test_nrst <= (kind == 1);
		end
		notes.push_back(n);
		repeat (5) @(posedge sys_clk);
		// Mid-reset look: emulation kept on warm and max, pins still straps
		@(negedge sys_clk);
		check(emu_rst_n, kind != 0);
		check(strap_mode, 1'b1);
		@(posedge sys_clk);
		max_rst_req <= 1'b0;
		nrst <= 1'b1;
		test_nrst <= 1'b1;
		k = 0;
		while (notes.size() != 0 && k < 20) begin
			@(posedge sys_clk);
			k++;
		end
		check(notes.size(), 0);
		notes.delete();
	endtask : do_reset

	task automatic sw_write(input logic [1:0] b, input logic [3:0] c);
		@(posedge sys_clk);
		sw_cfg_we <= 1'b1;
		sw_boot_sel <= b;
		sw_pin_cfg <= c;
		@(posedge sys_clk);
		sw_cfg_we <= 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask : sw_write

	task automatic start_boot();
		@(posedge sys_clk);
		boot_start <= 1'b1;
		@(posedge sys_clk);
		boot_start <= 1'b0;
		@(negedge sys_clk);
		check(defaults_active, 1'b0);
	endtask : start_boot

	// Main sequence
	initial begin
		nrst <= 1'b0;
		test_nrst <= 1'b0;
		max_rst_req <= 1'b0;
		boot_start <= 1'b0;
		sw_cfg_we <= 1'b0;
		sw_boot_sel <= 2'h0;
		sw_pin_cfg <= 4'h0;
		fit_en <= 1'b0;
		fit_bs <= 2'h3;
		fit_cfg <= 4'h2;
		do_reset(0, 2'h3, 4'h2, 1'b1);
		for (int i = 0; i < 12; i++) do_reset(1, 2'(i % 4), cfgs[i % 6], 1'b0);
		for (int i = 0; i < 4; i++) do_reset(i % 2, 2'($random(seed)), 4'($random(seed)), 1'b0);
		do_reset(1, 2'h3, 4'hC, 1'b0);
		sw_write(2'h0, 4'h3);
		check({boot_source_select, async_mem_pin_config}, 6'h3C);
		start_boot();
		sw_write(2'h1, 4'h2);
		check({boot_source_select, async_mem_pin_config}, 6'h12);
		for (int j = 0; j < 2; j++) begin
			do_reset(2, 2'($random(seed)), 4'($random(seed)), 1'b0);
			start_boot();
		end
		print_verdict();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		print_verdict();
	end
endmodule : rsdc_top_tb
